// ==== cbt_map.svh ====
// Register offsets, field positions, reset values and timing counts
// for the bit timing and synchronisation block.
// Assumes a 32-bit AXI4-Lite register bus, one register per aligned word.
`ifndef CBT_MAP_SVH
`define CBT_MAP_SVH

// ********************************************************
// Register byte offsets
// ********************************************************
`define CBT_OFS_PRESCALE_JUMP 32'h0000_0000
`define CBT_OFS_SEGMENTS      32'h0000_0004
`define CBT_OFS_PHASE2        32'h0000_0008
`define CBT_OFS_CONTROL       32'h0000_000C
`define CBT_OFS_STATUS        32'h0000_0010
`define CBT_ADDR_BITS         5

// ********************************************************
// Field positions
// ********************************************************
`define CBT_PRESCALE_LSB 0
`define CBT_PRESCALE_MSB 5
`define CBT_JUMP_LSB     6
`define CBT_JUMP_MSB     7
`define CBT_PROP_LSB     0
`define CBT_PROP_MSB     2
`define CBT_PH1_LSB      3
`define CBT_PH1_MSB      5
`define CBT_TRIPLE_BIT   6
`define CBT_PH2SEL_BIT   7
`define CBT_PH2_LSB      0
`define CBT_PH2_MSB      2
`define CBT_CFGMODE_BIT  0
`define CBT_STICKY_LSB   4
`define CBT_STICKY_MSB   6

// ********************************************************
// Reset values and fixed timing
// ********************************************************
`define CBT_RST_PRESCALE_JUMP 8'h00
`define CBT_RST_SEGMENTS      8'h00
`define CBT_RST_PHASE2        8'h01
`define CBT_RST_CFGMODE       1'h1
`define CBT_IPT_TQ            4'h2
`define CBT_CRC_POLY          15'h4599
`define CBT_RESP_OKAY         2'h0
`define CBT_RESP_SLVERR       2'h2

`endif

// ==== cbt_pkg.sv ====
// Types shared by the bit timing block and its surroundings.
// Assumes the protocol engine reports the field of the bit being sampled.
`default_nettype none
package cbt_pkg;

  // Bit time segments, Gray coded along sync-prop-ph1-ph2
  typedef enum logic [1:0] {
    CBT_SEG_SYNC = 2'b00,
    CBT_SEG_PROP = 2'b01,
    CBT_SEG_PH1  = 2'b11,
    CBT_SEG_PH2  = 2'b10
  } cbt_seg_t;

  // Frame field of the current bit
  typedef enum logic [2:0] {
    CBT_FLD_IDLE      = 3'h0,
    CBT_FLD_SOF_DATA  = 3'h1,
    CBT_FLD_CRC_SEQ   = 3'h2,
    CBT_FLD_CRC_DELIM = 3'h3,
    CBT_FLD_ACK_SLOT  = 3'h4,
    CBT_FLD_ACK_DELIM = 3'h5,
    CBT_FLD_EOF       = 3'h6,
    CBT_FLD_IFS       = 3'h7
  } cbt_field_t;

  // Frame state from the protocol engine
  typedef struct packed {
    cbt_field_t field;
    logic tx_active;
    logic rx_active;
    logic stuff_bit;
    logic bus_idle;
    logic tx_bit;
  } cbt_frame_t;

  // Error indications
  typedef struct packed {
    logic crc;
    logic ack;
    logic form;
  } cbt_err_t;

endpackage

`default_nettype wire

// ==== cbt_top.sv ====
// Bit timing, synchronisation and frame error checks of a CAN node.
// Assumes a protocol engine on MCLK_I supplying frame state, and a
// transceiver on the bus pins.
`include "cbt_map.svh"
`timescale 1ns/1ns
`default_nettype none

module cbt_top
  import cbt_pkg::*;
(
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RST_I,
  // Bus pins
  input wire logic RXD_I,
  output var logic TXD_O,
  // Protocol engine side
  input wire cbt_frame_t FRAME_I,
  output var logic BIT_START_O,
  output var logic SAMPLE_O,
  output var logic RX_BIT_O,
  output var cbt_err_t ERR_O,
  output var logic ERR_FRAME_O,
  output var logic RETX_O,
  // AXI4-Lite write channels
  input wire logic [31:0] AWADDR_I,
  input wire logic AWVALID_I,
  output var logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output var logic WREADY_O,
  output var logic [1:0] BRESP_O,
  output var logic BVALID_O,
  input wire logic BREADY_I,
  // AXI4-Lite read channels
  input wire logic [31:0] ARADDR_I,
  input wire logic ARVALID_I,
  output var logic ARREADY_O,
  output var logic [31:0] RDATA_O,
  output var logic [1:0] RRESP_O,
  output var logic RVALID_O,
  input wire logic RREADY_I
);

  // ********************************************************
  // Declarations
  // ********************************************************
  logic [7:0] cfg1_r, cfg2_r, cfg3_r;
  logic cfg_mode_r;
  logic [2:0] sticky_r;
  logic [31:0] aw_addr_r, w_data_r;
  logic aw_have_r, w_have_r, w_strb0_r;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic aw_take, w_take, do_wr, aw_have_nxt, w_have_nxt, ar_take, rvalid_nxt;
  logic [4:0] wr_ofs, rd_ofs;
  logic rx_m1_r, rx_s2_r, rx_prev_r;
  logic [5:0] pre_cnt_r;
  logic half_r;
  logic half_tick, tq_tick;
  cbt_seg_t seg_r;
  logic [3:0] tq_cnt_r;
  logic [2:0] ext_r, shrink_r;
  logic synced_r, last_bit_r;
  logic [1:0] samp_sh_r;
  logic [3:0] prop_len, ph1_len, ph2_base, ph2_eff, ph2_end, sjw_len;
  logic [4:0] err_mag;
  logic fall, use_edge, hard_sync, resync, pos_err, neg_err, restart;
  logic small_err, seg_end, sample_pt, smp_bit;
  logic txd_r, bit_start_r, sample_r, rx_bit_r, err_frame_r, retx_r;
  logic bit_go;
  cbt_err_t err_r, err_now;
  logic [14:0] crc_r;
  logic crc_fb;

  // ********************************************************
  // AXI4-Lite slave
  // ********************************************************
  assign aw_take = AWVALID_I && awready_r;
  assign w_take = WVALID_I && wready_r;
  assign do_wr = aw_have_r && w_have_r && !bvalid_r;
  assign aw_have_nxt = (aw_have_r && !do_wr) || aw_take;
  assign w_have_nxt = (w_have_r && !do_wr) || w_take;
  assign ar_take = ARVALID_I && arready_r;
  assign rvalid_nxt = (rvalid_r && !RREADY_I) || ar_take;
  assign wr_ofs = aw_addr_r[`CBT_ADDR_BITS-1:0];
  assign rd_ofs = ARADDR_I[`CBT_ADDR_BITS-1:0];

  // Address and data capture, either order
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      aw_addr_r <= 32'h0000_0000;
      w_data_r <= 32'h0000_0000;
      w_strb0_r <= 1'b0;
    end
    else
    begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      awready_r <= !aw_have_nxt;
      wready_r <= !w_have_nxt;
      if (aw_take)
        aw_addr_r <= AWADDR_I;
      if (w_take)
      begin
        w_data_r <= WDATA_I;
        w_strb0_r <= WSTRB_I[0];
      end
    end
  end

  // Write response
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= `CBT_RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= (aw_addr_r[31:`CBT_ADDR_BITS] == '0 && wr_ofs[1:0] == 2'h0 &&
                  {27'h000_0000, wr_ofs} <= `CBT_OFS_STATUS) ? `CBT_RESP_OKAY : `CBT_RESP_SLVERR;
    end
    else if (BREADY_I)
      bvalid_r <= 1'b0;
  end

  // Configuration registers, locked outside configuration mode
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      cfg1_r <= `CBT_RST_PRESCALE_JUMP;
      cfg2_r <= `CBT_RST_SEGMENTS;
      cfg3_r <= `CBT_RST_PHASE2;
      cfg_mode_r <= `CBT_RST_CFGMODE;
    end
    else if (do_wr && w_strb0_r && aw_addr_r[31:`CBT_ADDR_BITS] == '0)
    begin
      if (cfg_mode_r && {27'h000_0000, wr_ofs} == `CBT_OFS_PRESCALE_JUMP)
        cfg1_r <= w_data_r[7:0];
      if (cfg_mode_r && {27'h000_0000, wr_ofs} == `CBT_OFS_SEGMENTS)
        cfg2_r <= w_data_r[7:0];
      if (cfg_mode_r && {27'h000_0000, wr_ofs} == `CBT_OFS_PHASE2)
        cfg3_r <= w_data_r[7:0];
      if ({27'h000_0000, wr_ofs} == `CBT_OFS_CONTROL)
        cfg_mode_r <= w_data_r[`CBT_CFGMODE_BIT];
    end
  end

  // Sticky error flags, write one to clear, new error wins
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
      sticky_r <= 3'h0;
    else if (do_wr && w_strb0_r && aw_addr_r[31:`CBT_ADDR_BITS] == '0 &&
             {27'h000_0000, wr_ofs} == `CBT_OFS_STATUS)
      sticky_r <= (sticky_r & ~w_data_r[`CBT_STICKY_MSB:`CBT_STICKY_LSB]) | err_r;
    else
      sticky_r <= sticky_r | err_r;
  end

  // Read channel
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `CBT_RESP_OKAY;
    end
    else
    begin
      rvalid_r <= rvalid_nxt;
      arready_r <= !rvalid_nxt;
      if (ar_take)
      begin
        rdata_r <= 32'h0000_0000;
        rresp_r <= `CBT_RESP_OKAY;
        if (ARADDR_I[31:`CBT_ADDR_BITS] != '0)
          rresp_r <= `CBT_RESP_SLVERR;
        else
          unique case ({27'h000_0000, rd_ofs})
            `CBT_OFS_PRESCALE_JUMP: rdata_r[7:0] <= cfg1_r;
            `CBT_OFS_SEGMENTS: rdata_r[7:0] <= cfg2_r;
            `CBT_OFS_PHASE2: rdata_r[7:0] <= cfg3_r;
            `CBT_OFS_CONTROL: rdata_r[0] <= cfg_mode_r;
            `CBT_OFS_STATUS: rdata_r[7:0] <= {1'b0, sticky_r, FRAME_I.bus_idle, last_bit_r, seg_r};
            default: rresp_r <= `CBT_RESP_SLVERR;
          endcase
      end
    end
  end

  // ********************************************************
  // Receive pin synchroniser and edge detect
  // ********************************************************
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      rx_m1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_prev_r <= 1'b1;
    end
    else
    begin
      rx_m1_r <= RXD_I;
      rx_s2_r <= rx_m1_r;
      rx_prev_r <= rx_s2_r;
    end
  end

  // Only recessive to dominant counts
  assign fall = rx_prev_r && !rx_s2_r;

  // ********************************************************
  // Time quantum prescaler
  // ********************************************************
  // Half tick every prescale+1 clocks; quantum is twice that
  assign half_tick = pre_cnt_r == cfg1_r[`CBT_PRESCALE_MSB:`CBT_PRESCALE_LSB];
  assign tq_tick = half_tick && half_r;

  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      pre_cnt_r <= 6'h00;
      half_r <= 1'b0;
    end
    else if (restart)
    begin
      pre_cnt_r <= 6'h00;
      half_r <= 1'b0;
    end
    else if (half_tick)
    begin
      pre_cnt_r <= 6'h00;
      half_r <= !half_r;
    end
    else
      pre_cnt_r <= pre_cnt_r + 6'h01;
  end

  // ********************************************************
  // Segment lengths
  // ********************************************************
  assign sjw_len = {2'b00, cfg1_r[`CBT_JUMP_MSB:`CBT_JUMP_LSB]} + 4'h1;
  assign prop_len = {1'b0, cfg2_r[`CBT_PROP_MSB:`CBT_PROP_LSB]} + 4'h1;
  assign ph1_len = {1'b0, cfg2_r[`CBT_PH1_MSB:`CBT_PH1_LSB]} + 4'h1 + {1'b0, ext_r};
  // Phase 2 base from its own field or from phase 1
  assign ph2_base = cfg2_r[`CBT_PH2SEL_BIT] ? {1'b0, cfg3_r[`CBT_PH2_MSB:`CBT_PH2_LSB]} + 4'h1
                                            : {1'b0, cfg2_r[`CBT_PH1_MSB:`CBT_PH1_LSB]} + 4'h1;
  assign ph2_eff = (ph2_base < `CBT_IPT_TQ) ? `CBT_IPT_TQ : ph2_base;
  assign ph2_end = (ph2_eff > {1'b0, shrink_r}) ? ph2_eff - {1'b0, shrink_r} : 4'h1;

  always_comb
  begin
    unique case (seg_r)
      CBT_SEG_SYNC: seg_end = 1'b1;
      CBT_SEG_PROP: seg_end = tq_cnt_r + 4'h1 >= prop_len;
      CBT_SEG_PH1: seg_end = tq_cnt_r + 4'h1 >= ph1_len;
      CBT_SEG_PH2: seg_end = tq_cnt_r + 4'h1 >= ph2_end;
    endcase
  end

  // ********************************************************
  // Synchronisation decision
  // ********************************************************
  assign use_edge = fall && last_bit_r && !synced_r;
  assign hard_sync = use_edge && FRAME_I.bus_idle;
  assign resync = use_edge && !FRAME_I.bus_idle;
  assign pos_err = seg_r == CBT_SEG_PROP || seg_r == CBT_SEG_PH1;
  assign neg_err = seg_r == CBT_SEG_PH2;

  // Phase error magnitude in quanta
  always_comb
  begin
    unique case (seg_r)
      CBT_SEG_PROP: err_mag = {1'b0, tq_cnt_r} + 5'h01;
      CBT_SEG_PH1: err_mag = {1'b0, prop_len} + {1'b0, tq_cnt_r} + 5'h01;
      CBT_SEG_PH2: err_mag = {1'b0, ph2_end} - {1'b0, tq_cnt_r};
      CBT_SEG_SYNC: err_mag = 5'h00;
    endcase
  end

  assign small_err = err_mag <= {1'b0, sjw_len};
  // Realign when hard sync or a small error allowed
  assign restart = hard_sync || (resync && small_err &&
                   (neg_err || (pos_err && txd_r)));
  assign sample_pt = tq_tick && seg_r == CBT_SEG_PH1 && seg_end && !restart;

  // Majority of three or the single sample point value
  assign smp_bit = cfg2_r[`CBT_TRIPLE_BIT] ?
                   ((rx_s2_r & samp_sh_r[0]) | (rx_s2_r & samp_sh_r[1]) | (samp_sh_r[0] & samp_sh_r[1]))
                   : rx_s2_r;

  // ********************************************************
  // Bit time sequencer
  // ********************************************************
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      seg_r <= CBT_SEG_SYNC;
      tq_cnt_r <= 4'h0;
      ext_r <= 3'h0;
      shrink_r <= 3'h0;
      synced_r <= 1'b0;
    end
    else if (restart)
    begin
      // Edge now lies in a fresh sync segment
      seg_r <= CBT_SEG_SYNC;
      tq_cnt_r <= 4'h0;
      ext_r <= 3'h0;
      shrink_r <= 3'h0;
      synced_r <= 1'b1;
    end
    else
    begin
      if (resync && pos_err && !small_err && txd_r)
      begin
        ext_r <= sjw_len[2:0];
        synced_r <= 1'b1;
      end
      else if (resync && neg_err && !small_err)
      begin
        shrink_r <= sjw_len[2:0];
        synced_r <= 1'b1;
      end
      if (tq_tick)
      begin
        if (seg_end)
        begin
          tq_cnt_r <= 4'h0;
          unique case (seg_r)
            CBT_SEG_SYNC: seg_r <= CBT_SEG_PROP;
            CBT_SEG_PROP: seg_r <= CBT_SEG_PH1;
            CBT_SEG_PH1: seg_r <= CBT_SEG_PH2;
            CBT_SEG_PH2:
            begin
              seg_r <= CBT_SEG_SYNC;
              ext_r <= 3'h0;
              shrink_r <= 3'h0;
              synced_r <= 1'b0;
            end
          endcase
        end
        else
          tq_cnt_r <= tq_cnt_r + 4'h1;
      end
    end
  end

  // Half-quantum sample history and received bit
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      samp_sh_r <= 2'b11;
      last_bit_r <= 1'b1;
    end
    else
    begin
      if (half_tick)
        samp_sh_r <= {samp_sh_r[0], rx_s2_r};
      if (sample_pt)
        last_bit_r <= smp_bit;
      else if (FRAME_I.bus_idle && !rx_s2_r)
        last_bit_r <= 1'b1;
    end
  end

  // ********************************************************
  // Transmit pin and bit strobes
  // ********************************************************
  // New bit: hard sync, early edge in phase 2, or normal end of phase 2
  assign bit_go = hard_sync || (restart && neg_err) ||
                  (tq_tick && seg_r == CBT_SEG_PH2 && seg_end && !restart);

  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      txd_r <= 1'b1;
      bit_start_r <= 1'b0;
      sample_r <= 1'b0;
      rx_bit_r <= 1'b1;
    end
    else
    begin
      bit_start_r <= bit_go;
      sample_r <= sample_pt;
      if (sample_pt)
        rx_bit_r <= smp_bit;
      // New bit leaves the pin on hard sync, on an early edge in phase 2, or at the end of phase 2
      if (bit_go)
        txd_r <= !FRAME_I.tx_active || FRAME_I.tx_bit ||
                 FRAME_I.field == CBT_FLD_ACK_SLOT;
    end
  end

  // ********************************************************
  // Frame error checks
  // ********************************************************
  assign crc_fb = smp_bit ^ crc_r[14];

  always_comb
  begin
    err_now.crc = FRAME_I.rx_active && FRAME_I.field == CBT_FLD_CRC_DELIM && crc_r != 15'h0000;
    err_now.ack = FRAME_I.tx_active && FRAME_I.field == CBT_FLD_ACK_SLOT && smp_bit;
    err_now.form = !smp_bit && (FRAME_I.field == CBT_FLD_CRC_DELIM ||
                   FRAME_I.field == CBT_FLD_ACK_DELIM ||
                   FRAME_I.field == CBT_FLD_EOF || FRAME_I.field == CBT_FLD_IFS);
  end

  // Running CRC through the CRC field; zero remainder means match
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
      crc_r <= 15'h0000;
    else if (FRAME_I.bus_idle || FRAME_I.field == CBT_FLD_IDLE)
      crc_r <= 15'h0000;
    else if (sample_pt && !FRAME_I.stuff_bit &&
             (FRAME_I.field == CBT_FLD_SOF_DATA || FRAME_I.field == CBT_FLD_CRC_SEQ))
      crc_r <= {crc_r[13:0], 1'b0} ^ (crc_fb ? `CBT_CRC_POLY : 15'h0000);
  end

  // One-cycle error pulses with error frame and retry
  always_ff @(posedge MCLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      err_r <= 3'h0;
      err_frame_r <= 1'b0;
      retx_r <= 1'b0;
    end
    else
    begin
      err_r <= sample_pt ? err_now : 3'h0;
      err_frame_r <= sample_pt && (|err_now);
      retx_r <= sample_pt && FRAME_I.tx_active && (|err_now);
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign TXD_O = txd_r;
  assign BIT_START_O = bit_start_r;
  assign SAMPLE_O = sample_r;
  assign RX_BIT_O = rx_bit_r;
  assign ERR_O = err_r;
  assign ERR_FRAME_O = err_frame_r;
  assign RETX_O = retx_r;
  assign AWREADY_O = awready_r;
  assign WREADY_O = wready_r;
  assign BVALID_O = bvalid_r;
  assign BRESP_O = bresp_r;
  assign ARREADY_O = arready_r;
  assign RVALID_O = rvalid_r;
  assign RDATA_O = rdata_r;
  assign RRESP_O = rresp_r;

endmodule // cbt_top

`default_nettype wire

// ==== cbt_asserts.sv ====
// Port checker for the bit timing block.
// Assumes it is bound onto cbt_top.
`timescale 1ns/1ns
`default_nettype none
module cbt_asserts
  import cbt_pkg::*;
(
  // Clock, reset and frame state
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire cbt_frame_t FRAME_I,
  // Bit timing outputs
  input wire logic TXD_O,
  input wire logic BIT_START_O,
  input wire logic SAMPLE_O,
  input wire logic RX_BIT_O,
  input wire cbt_err_t ERR_O,
  input wire logic ERR_FRAME_O,
  input wire logic RETX_O,
  // Write response
  input wire logic BVALID_O,
  input wire logic BREADY_I
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  // ****
  // Properties
  // ****
  err_at_sample_a: assert property (ERR_O != 3'h0 |-> SAMPLE_O)
    else $error("error flag off sample");
  err_one_cycle_a: assert property (ERR_O != 3'h0 |=> ERR_O == 3'h0)
    else $error("error flag too long");
  ack_cause_a: assert property (ERR_O.ack |-> FRAME_I.tx_active && FRAME_I.field == CBT_FLD_ACK_SLOT && RX_BIT_O)
    else $error("ack error without cause");
  form_cause_a: assert property (ERR_O.form |-> !RX_BIT_O &&
    FRAME_I.field inside {CBT_FLD_CRC_DELIM, CBT_FLD_ACK_DELIM, CBT_FLD_EOF, CBT_FLD_IFS})
    else $error("form error without cause");
  crc_cause_a: assert property (ERR_O.crc |-> FRAME_I.rx_active && FRAME_I.field == CBT_FLD_CRC_DELIM)
    else $error("crc error off delimiter");
  tx_at_start_a: assert property ($changed(TXD_O) |-> BIT_START_O)
    else $error("transmit moved mid bit");
  rx_at_sample_a: assert property ($changed(RX_BIT_O) && !FRAME_I.bus_idle |-> ##[0:1] SAMPLE_O)
    else $error("received bit moved off sample");
  sample_spacing_a: assert property (SAMPLE_O |=> !SAMPLE_O [*5])
    else $error("samples too close");
  bresp_hold_a: assert property (BVALID_O && !BREADY_I |=> BVALID_O)
    else $error("write response dropped");
  err_frame_a: assert property (ERR_FRAME_O == (ERR_O != 3'h0))
    else $error("error frame request mismatch");
  retx_cause_a: assert property (RETX_O |-> ERR_O != 3'h0 && FRAME_I.tx_active)
    else $error("retransmit without transmit error");
  // Main scenarios
  cover property (ERR_O.crc);
  cover property (ERR_O.ack);
  cover property (BIT_START_O && FRAME_I.bus_idle);
endmodule // cbt_asserts
`default_nettype wire

// ==== cbt_bus_model.sv ====
// Other nodes on the bus, behind their transceivers.
// Assumes a wired-AND line with a recessive pull-up.
`timescale 1ns/1ns
`default_nettype none
module cbt_bus_model
(
  // Local transmit pin
  input wire logic txd_i,
  // Line level as received
  output var logic rxd_o
);
  // Level driven by the other nodes, set by the bench
  logic lvl_r = 1'h1;
  // Dominant from any node wins
  assign rxd_o = txd_i & lvl_r;
endmodule // cbt_bus_model
`default_nettype wire

// ==== test_can_bit_timing_sync.sv ====
// Self-checking bench for the bit timing block.
// Assumes cbt_top, cbt_bus_model and cbt_asserts.
`include "cbt_map.svh"
`timescale 1ns/1ns
`default_nettype none
module test_can_bit_timing_sync
  import cbt_pkg::*;
;
  // ****
  // Signals
  // ****
  logic clk = 1'h0, rst = 1'h1, rxd, txd, smp, rxb, awr, wrd, bv, arr, rv, efr, rtx;
  logic awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
  logic [31:0] awa = '0, wd = '0, ara = '0, rdd;
  logic [1:0] br, rr;
  cbt_err_t err;
  cbt_frame_t frm = '{CBT_FLD_IDLE, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1};
  int fails = 0, n_compared = 0;
  // Bit timing settings and bit length in clocks
  logic [7:0] cfg [5][3] = '{'{8'h00, 8'h80, 8'h00}, '{8'h40, 8'h94, 8'h07}, '{8'h00, 8'h62, 8'h07},
    '{8'h01, 8'h00, 8'h05}, '{8'h3F, 8'h3F, 8'h00}};
  int clks [5] = '{10, 34, 28, 20, 3200};
  // Design, far side and clock
  cbt_top dut_u (.MCLK_I(clk), .RST_I(rst), .RXD_I(rxd), .TXD_O(txd), .FRAME_I(frm),
    .BIT_START_O(), .SAMPLE_O(smp), .RX_BIT_O(rxb), .ERR_O(err), .ERR_FRAME_O(efr), .RETX_O(rtx),
    .AWADDR_I(awa), .AWVALID_I(awv), .AWREADY_O(awr), .WDATA_I(wd), .WSTRB_I(4'hF), .WVALID_I(wv),
    .WREADY_O(wrd), .BRESP_O(br), .BVALID_O(bv), .BREADY_I(bry), .ARADDR_I(ara), .ARVALID_I(arv),
    .ARREADY_O(arr), .RDATA_O(rdd), .RRESP_O(rr), .RVALID_O(rv), .RREADY_I(rry));
  cbt_bus_model bus_u (.txd_i(txd), .rxd_o(rxd));
  initial forever #25 clk = ~clk;
  // ****
  // Tasks
  // ****
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
  endtask
  task automatic conclude();
    if (fails == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Register write, address and data offered together
  task automatic wr(input logic [31:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge clk);
    awa <= a;
    wd <= {24'h00_0000, d};
    awv <= 1'h1;
    wv <= 1'h1;
    bry <= 1'h1;
    do
    begin
      @(posedge clk);
      if (awr) awv <= 1'h0;
      if (wrd) wv <= 1'h0;
    end
    while (bv !== 1'h1);
    bry <= 1'h0;
    r = br;
  endtask
  // Register read
  task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge clk);
    ara <= a;
    arv <= 1'h1;
    rry <= 1'h1;
    do
    begin
      @(posedge clk);
      if (arr) arv <= 1'h0;
    end
    while (rv !== 1'h1);
    rry <= 1'h0;
    v = rdd;
    r = rr;
  endtask
  task automatic wsamp();
    do @(posedge clk); while (smp !== 1'h1);
  endtask
  // Clocks between two samples, bus set to l after d clocks
  task automatic gap(input int d, input logic l, output int n);
    n = 0;
    wsamp();
    repeat (d)
    begin
      @(posedge clk);
      n++;
    end
    bus_u.lvl_r <= l;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (smp !== 1'h1);
  endtask
  // Flags of the bit just sampled, then set up the next bit
  task automatic step(input cbt_field_t f, input logic t, input logic l, output cbt_err_t e);
    wsamp();
    e = err;
    frm.field <= f;
    frm.tx_active <= t;
    frm.tx_bit <= l;
    bus_u.lvl_r <= l;
  endtask
  // ****
  // Tests
  // ****
  initial
  begin
    logic [31:0] v;
    logic [1:0] r;
    int n;
    cbt_err_t e;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 4; i++)
    begin
      rd(32'(i * 4), v, r);
      chk("reset value", (i > 1) ? 32'h0000_0001 : 32'h0000_0000, v);
    end
    rd(32'h0000_0014, v, r);
    chk("read resp", 32'h0000_0002, 32'(r));
    wr(32'h0000_0014, 8'h00, r);
    chk("write resp", 32'h0000_0002, 32'(r));
    wr(`CBT_OFS_CONTROL, 8'h00, r);
    gap(4, 1'h0, n);
    chk("hard sync gap", 32'h0000_0001, 32'(n > 11 && n < 18));
    chk("bit after sync", 32'h0000_0000, 32'(rxb));
    frm.bus_idle <= 1'h0;
    gap(3, 1'h1, n);
    chk("rising edge gap", 32'h0000_000A, 32'(n));
    step(CBT_FLD_SOF_DATA, 1'h0, 1'h0, e);
    step(CBT_FLD_SOF_DATA, 1'h0, 1'h1, e);
    step(CBT_FLD_CRC_DELIM, 1'h0, 1'h1, e);
    step(CBT_FLD_EOF, 1'h0, 1'h0, e);
    chk("crc flag", 32'h0000_0004, 32'(e));
    step(CBT_FLD_ACK_SLOT, 1'h1, 1'h1, e);
    chk("form flag", 32'h0000_0001, 32'(e));
    chk("form error frame", 32'h0000_0001, 32'(efr));
    chk("form retransmit", 32'h0000_0000, 32'(rtx));
    step(CBT_FLD_IDLE, 1'h0, 1'h1, e);
    chk("ack flag", 32'h0000_0002, 32'(e));
    chk("ack retransmit", 32'h0000_0001, 32'(rtx));
    rd(`CBT_OFS_STATUS, v, r);
    chk("sticky flags", 32'h0000_0070, v & 32'h0000_0070);
    wr(`CBT_OFS_STATUS, 8'h70, r);
    rd(`CBT_OFS_STATUS, v, r);
    chk("sticky clear", 32'h0000_0000, v & 32'h0000_0070);
    frm.bus_idle <= 1'h1;
    for (int i = 0; i < 5; i++)
    begin
      wr(`CBT_OFS_CONTROL, 8'h01, r);
      for (int j = 0; j < 3; j++) wr(32'(j * 4), cfg[i][j], r);
      wr(`CBT_OFS_CONTROL, 8'h00, r);
      wr(`CBT_OFS_PRESCALE_JUMP, ~cfg[i][0], r);
      rd(`CBT_OFS_PRESCALE_JUMP, v, r);
      chk("locked register", 32'(cfg[i][0]), v);
      gap(1, 1'h1, n);
      chk("bit length", 32'(clks[i]), 32'(n));
      if (i == 1)
      begin
        // Resync inside a frame: early edge, ignored rising edge, late edge
        frm.bus_idle <= 1'h0;
        gap(1, 1'h0, n);
        chk("shortened bit", 32'h0000_001E, 32'(n));
        gap(1, 1'h1, n);
        chk("rising edge bit", 32'h0000_0022, 32'(n));
        gap(20, 1'h0, n);
        chk("lengthened bit", 32'h0000_0026, 32'(n));
        bus_u.lvl_r <= 1'h1;
        frm.bus_idle <= 1'h1;
      end
    end
    conclude();
  end
  // Watchdog against a hang
  initial
  begin
    repeat (40000) @(posedge clk);
    fails++;
    conclude();
  end
endmodule // test_can_bit_timing_sync
bind cbt_top cbt_asserts chk_u (.*);
`default_nettype wire
